// ### core/psr_pkg.sv
// Purpose: constants for the pseudo-static ram host controller
// Assumes: 250 MHz system clock, fastest speed grade timings
// Notes:   least times round up, longest times round down
package psr_pkg;
  localparam int CLK_PERIOD_PS        = 4000;
  localparam int POWERUP_WAIT_US      = 100;
  localparam int INIT_CYCLES          = 8;
  localparam int REFRESH_WINDOW_MS    = 32;
  localparam int REFRESH_ROWS         = 2048;
  localparam int SELF_EXIT_DEADLINE_US = 15;
  localparam int SELF_REFRESH_EXIT_TIME_NS   = 600;
  localparam int SELF_REFRESH_PULSE_WIDTH_US = 8;
  localparam int AUTO_REFRESH_PULSE_WIDTH_NS = 70;
  localparam int AUTO_REFRESH_CYCLE_TIME_NS  = 115;
  localparam int REFRESH_INTERVAL_NS  = 15600;
  localparam int ACCESS_CYCLE_NS      = 115;
  localparam int STROBE_LOW_NS        = 70;
  localparam int DATA_SETUP_NS        = 20;

  // least times: round up
  localparam int POWERUP_CYC   = (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int SR_EXIT_CYC   = (SELF_REFRESH_EXIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SR_PULSE_CYC  = (SELF_REFRESH_PULSE_WIDTH_US * 1000000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int AR_PULSE_CYC  = (AUTO_REFRESH_PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int AR_CYCLE_CYC  = (AUTO_REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int ACC_CYCLE_CYC = (ACCESS_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYC    = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DSETUP_CYC    = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest time: round down
  localparam int REF_INT_CYC   = REFRESH_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
endpackage

// ### core/psr_host.sv
// Purpose: host controller for an asynchronous pseudo-static ram
// Assumes: one 250 MHz clock; device pins registered
// Notes:   refresh has priority over user accesses once due
`timescale 1ns/1ns
// How it works
// RULE_01: device writes only while chip select and write strobe both low
// RULE_02: write ends at first rise of write strobe or chip select
// RULE_03: chip select falling with or after write strobe keeps outputs off
// RULE_04: output enable off before driving data; release data before re-enable
// RULE_05: after power-up wait over 100 us, then eight dummy cycles
// RULE_06: all 2048 refreshes within each 32 ms window
// RULE_07: refresh within 15 us after leaving self refresh
// RULE_08: chip select and strobe high 600 ns on self refresh exit
// RULE_09: no refresh strobe fall during self refresh exit time
// RULE_10: strobe low at least 8 us enters self refresh until release
// RULE_11: auto refresh pulse 70 ns to under 8 us, 115 ns apart
// RULE_12: strobe low with chip select high refreshes, else output enable
// RULE_13: never emit a refresh pulse shorter than minimum width
// RULE_14: interval counter issues refresh every 15.6 us, keeps deferred ones
module psr_host import psr_pkg::*; #(
  parameter int AW          = 19,
  parameter int DW          = 8,
  parameter int POWERUP_CNT = POWERUP_CYC,
  parameter int REF_INT_CNT = REF_INT_CYC,
  parameter int SR_PULSE_CNT = SR_PULSE_CYC
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          req_valid_i,
  input  wire logic          req_write_i,
  input  wire logic [AW-1:0] req_addr_i,
  input  wire logic [DW-1:0] req_wdata_i,
  output logic               req_ready_o,
  output logic               rsp_valid_o,
  output logic [DW-1:0]      rsp_rdata_o,
  input  wire logic          self_refresh_req_i,
  output logic               self_refresh_o,
  output logic               init_done_o,
  output logic               chip_sel_n_o,
  output logic               write_strobe_n_o,
  output logic               output_or_refresh_strobe_n_o,
  output logic [AW-1:0]      addr_o,
  input  wire logic [DW-1:0] data_i,
  output logic [DW-1:0]      data_o,
  output logic               data_oe_o
);
  initial begin
    if (AW < 1 || DW < 1 || POWERUP_CNT < 2 || REF_INT_CNT < 2 * AR_CYCLE_CYC
        || SR_PULSE_CNT < 1)
      $error("psr_host: parameter out of range");
  end
  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  typedef enum {ST_POWERUP, ST_INIT, ST_IDLE, ST_RD, ST_WR, ST_AR_LOW, ST_AR_HIGH,
                ST_SR_LOW, ST_SR_EXIT} psr_state_e;

  typedef struct packed {
    psr_state_e    st;
    logic [31:0]   cnt;
    logic [31:0]   ref_tmr;
    logic [7:0]    owed;
    logic [3:0]    init_n;
    logic          ce_n;
    logic          we_n;
    logic          oe_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dout;
    logic          doe;
    logic [DW-1:0] rdata;
    logic          rvalid;
    logic          sr;
    logic          done;
  } psr_state_s;

  psr_state_s s_r, s_nxt;
  logic [DW-1:0] din_meta_r, din_sync_r;
  logic [1:0]    srq_sync_r;

  // pin data and async request pass two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
      srq_sync_r <= 2'b00;
    end else begin
      din_meta_r <= data_i;
      din_sync_r <= din_meta_r;
      srq_sync_r <= {srq_sync_r[0], self_refresh_req_i};
    end
  end

  logic ref_due;
  assign ref_due = (s_r.owed != 8'h00);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.cnt    = (s_r.cnt != 32'h0) ? s_r.cnt - 32'h1 : 32'h0;
    // RULE_14 interval counter pacing
    if (s_r.done && s_r.st != ST_SR_LOW) begin
      if (s_r.ref_tmr >= 32'(REF_INT_CNT - 1)) begin
        s_nxt.ref_tmr = 32'h0;
        if (s_r.owed != 8'hff) s_nxt.owed = s_r.owed + 8'h01;
      end else begin
        s_nxt.ref_tmr = s_r.ref_tmr + 32'h1;
      end
    end
    case (s_r.st)
      ST_POWERUP: begin
        // RULE_05 power-up pause
        if (s_r.cnt == 32'h0) begin
          s_nxt.st     = ST_INIT;
          s_nxt.init_n = 4'(INIT_CYCLES);
        end
      end
      ST_INIT: begin
        // RULE_05 dummy refresh cycles
        if (s_r.init_n == 4'h0) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.init_n = s_r.init_n - 4'h1;
          s_nxt.oe_n   = 1'b0;
          s_nxt.cnt    = 32'(AR_PULSE_CYC - 1);
          s_nxt.st     = ST_AR_LOW;
        end
      end
      ST_IDLE: begin
        if (srq_sync_r[1]) begin
          // RULE_10 long strobe low
          s_nxt.oe_n = 1'b0;
          s_nxt.sr   = 1'b1;
          s_nxt.cnt  = 32'(SR_PULSE_CNT - 1);
          s_nxt.st   = ST_SR_LOW;
        end else if (ref_due) begin
          // RULE_12 strobe low with chip select high
          s_nxt.oe_n = 1'b0;
          s_nxt.owed = s_nxt.owed - 8'h01;
          s_nxt.cnt  = 32'(AR_PULSE_CYC - 1);
          s_nxt.st   = ST_AR_LOW;
        end else if (req_valid_i) begin
          s_nxt.addr = req_addr_i;
          s_nxt.ce_n = 1'b0;
          s_nxt.cnt  = 32'(ACC_CYCLE_CYC - 1);
          if (req_write_i) begin
            // RULE_03 write strobe falls with chip select
            // RULE_04 output enable stays high in writes
            s_nxt.we_n = 1'b0;
            s_nxt.dout = req_wdata_i;
            s_nxt.doe  = 1'b1;
            s_nxt.st   = ST_WR;
          end else begin
            s_nxt.oe_n = 1'b0;
            s_nxt.st   = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (s_r.cnt == 32'(ACC_CYCLE_CYC - 1 - STROBE_CYC - 2)) begin
          s_nxt.rdata = din_sync_r;
          s_nxt.ce_n  = 1'b1;
          s_nxt.oe_n  = 1'b1;
        end
        if (s_r.cnt == 32'h0) begin
          s_nxt.rvalid = 1'b1;
          s_nxt.st     = ST_IDLE;
        end
      end
      ST_WR: begin
        // RULE_01 RULE_02 write ends on strobe rise
        if (s_r.cnt == 32'(ACC_CYCLE_CYC - 1 - STROBE_CYC)) begin
          s_nxt.we_n = 1'b1;
          s_nxt.ce_n = 1'b1;
        end
        // RULE_04 data released after strobe rise
        if (s_r.cnt == 32'(ACC_CYCLE_CYC - 2 - STROBE_CYC)) s_nxt.doe = 1'b0;
        if (s_r.cnt == 32'h0) s_nxt.st = ST_IDLE;
      end
      ST_AR_LOW: begin
        // RULE_11 RULE_13 full pulse width
        if (s_r.cnt == 32'h0) begin
          s_nxt.oe_n = 1'b1;
          s_nxt.cnt  = 32'(AR_CYCLE_CYC - AR_PULSE_CYC - 1);
          s_nxt.st   = ST_AR_HIGH;
        end
      end
      ST_AR_HIGH: begin
        // RULE_11 cycle spacing
        if (s_r.cnt == 32'h0) s_nxt.st = s_r.done ? ST_IDLE : ST_INIT;
      end
      ST_SR_LOW: begin
        if (s_r.cnt == 32'h0 && !srq_sync_r[1]) begin
          // RULE_08 RULE_09 exit holds pins high
          s_nxt.oe_n = 1'b1;
          s_nxt.cnt  = 32'(SR_EXIT_CYC - 1);
          s_nxt.st   = ST_SR_EXIT;
        end
      end
      ST_SR_EXIT: begin
        // RULE_07 RULE_06 refresh owed right after exit
        if (s_r.cnt == 32'h0) begin
          s_nxt.sr      = 1'b0;
          s_nxt.ref_tmr = 32'h0;
          if (s_r.owed == 8'h00) s_nxt.owed = 8'h01;
          s_nxt.st      = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r         <= '0;
      s_r.st      <= ST_POWERUP;
      s_r.cnt     <= 32'(POWERUP_CNT - 1);
      s_r.ce_n    <= 1'b1;
      s_r.we_n    <= 1'b1;
      s_r.oe_n    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o  = (s_r.st == ST_IDLE) && !ref_due && !srq_sync_r[1];
  assign rsp_valid_o  = s_r.rvalid;
  assign rsp_rdata_o  = s_r.rdata;
  assign self_refresh_o = s_r.sr;
  assign init_done_o  = s_r.done;
  assign chip_sel_n_o = s_r.ce_n;
  assign write_strobe_n_o = s_r.we_n;
  assign output_or_refresh_strobe_n_o = s_r.oe_n;
  assign addr_o       = s_r.addr;
  assign data_o       = s_r.dout;
  assign data_oe_o    = s_r.doe;
  // helper runs: counters stand in for long unrolled repetitions
  logic [31:0] low_run_r;
  logic [31:0] hi_run_r;
  logic [31:0] ar_gap_r;
  wire         ar_start = !s_r.oe_n && s_r.ce_n && (low_run_r == 32'h0);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_run_r <= 32'h0;
      hi_run_r  <= 32'h0;
      ar_gap_r  <= 32'hffff_ffff;
    end else begin
      low_run_r <= (!s_r.oe_n && s_r.ce_n) ? low_run_r + 32'h1 : 32'h0;
      hi_run_r  <= (s_r.oe_n && s_r.ce_n) ? hi_run_r + 32'h1 : 32'h0;
      if (ar_start) ar_gap_r <= 32'h1;
      else if (ar_gap_r != 32'hffff_ffff) ar_gap_r <= ar_gap_r + 32'h1;
    end
  end
  property p_no_short_refresh;
    ($rose(s_r.oe_n) && $past(s_r.ce_n)) |-> (low_run_r >= 32'(AR_PULSE_CYC));
  endproperty
  a_no_short_refresh: assert property (p_no_short_refresh) else $error("short pulse"); // RULE_13
  property p_write_no_oe;
    data_oe_o |-> output_or_refresh_strobe_n_o;
  endproperty
  a_write_no_oe: assert property (p_write_no_oe) else $error("data driven under oe"); // RULE_04
  property p_write_overlap;
    $fell(write_strobe_n_o) |-> $fell(chip_sel_n_o) ##1 (!write_strobe_n_o && data_oe_o)[*8];
  endproperty
  a_write_overlap: assert property (p_write_overlap) else $error("write misaligned"); // RULE_03
  property p_data_release;
    $rose(write_strobe_n_o) |-> data_oe_o ##1 !data_oe_o;
  endproperty
  a_data_release: assert property (p_data_release) else $error("data not held"); // RULE_02
  property p_sr_exit;
    (s_r.st == ST_SR_LOW && s_nxt.st == ST_SR_EXIT) |=>
      (output_or_refresh_strobe_n_o && chip_sel_n_o)[*8];
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("pins low in exit"); // RULE_08
  property p_sr_exit_len;
    $fell(self_refresh_o) |-> (hi_run_r >= 32'(SR_EXIT_CYC));
  endproperty
  a_sr_exit_len: assert property (p_sr_exit_len) else $error("exit time too short"); // RULE_09
  property p_after_exit;
    $fell(self_refresh_o) |-> ##[1:20] (!output_or_refresh_strobe_n_o && chip_sel_n_o);
  endproperty
  a_after_exit: assert property (p_after_exit) else $error("no refresh after exit"); // RULE_07
  property p_ar_spacing;
    ar_start |-> (ar_gap_r >= 32'(AR_CYCLE_CYC));
  endproperty
  a_ar_spacing: assert property (p_ar_spacing) else $error("refresh cycles too close"); // RULE_11
  property p_init_before_use;
    !init_done_o |-> !req_ready_o;
  endproperty
  a_init_before_use: assert property (p_init_before_use) else $error("ready before init"); // RULE_05
  property p_owed_bounded;
    s_r.owed <= 8'h02 || s_r.sr;
  endproperty
  a_owed_bounded: assert property (p_owed_bounded) else $error("refresh backlog"); // RULE_14

  c_write: cover property (@(posedge sys_clk_i) $rose(write_strobe_n_o));
  c_read: cover property (@(posedge sys_clk_i) rsp_valid_o);
  c_auto: cover property (@(posedge sys_clk_i) init_done_o && s_r.st == ST_AR_LOW);
  c_self: cover property (@(posedge sys_clk_i) $fell(self_refresh_o));
endmodule // psr_host

// ### dv/psr_dev_model.sv
// Purpose: behavioural pseudo-static ram seen by the host controller
// Assumes: pulse widths measured in ns from simulation time
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ns
module psr_dev_model #(
  parameter int SELF_NS = 160
) (
  input  wire logic        chip_sel_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        output_or_refresh_strobe_n_n_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        host_oe_i,
  output logic [7:0]       rdata_o,
  output int               ref_cnt_o,
  output int               self_cnt_o,
  output int               err_cnt_o
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q;
  logic       drive;
  logic       in_ref;
  logic       exit_pend;
  time        t_fall;
  time        t_exit;
  time        t_now;
  logic       wr_on;
  initial begin
    ref_cnt_o = 0;
    self_cnt_o = 0;
    err_cnt_o = 0;
    in_ref = 0;
    exit_pend = 0;
    t_fall = 0;
    last_q = 8'h00;
  end
  assign drive = !chip_sel_n_i && !output_or_refresh_strobe_n_n_i && write_strobe_n_i;
  assign rdata_o = drive ? mem[addr_i[7:0]] : ~last_q;
  always @(rdata_o) if (drive) last_q = rdata_o;
  always @(drive or host_oe_i) if (drive && host_oe_i) err_cnt_o++;
  // store at first release
  // one overlap net, so a simultaneous rise of both strobes is not missed
  assign wr_on = !chip_sel_n_i && !write_strobe_n_i;
  always @(negedge wr_on) mem[addr_i[7:0]] = host_oe_i ? wdata_i : ~wdata_i;
  // refresh start
  // look 1 ns later: chip select and strobe fall in one time step on reads
  always @(negedge output_or_refresh_strobe_n_n_i) begin
    t_now = $time;
    #1;
    if (chip_sel_n_i && !output_or_refresh_strobe_n_n_i) begin
      if (in_ref || (t_now - t_fall < 115)) err_cnt_o++;
      if (exit_pend && (t_now - t_exit < 600 || t_now - t_exit > 15000)) err_cnt_o++;
      exit_pend = 0;
      t_fall = t_now;
      in_ref = 1;
    end
  end
  always @(posedge output_or_refresh_strobe_n_n_i) if (in_ref) begin
    in_ref = 0;
    if ($time - t_fall < 70) err_cnt_o++;
    else if ($time - t_fall >= SELF_NS) begin
      self_cnt_o++;
      exit_pend = 1;
      t_exit = $time;
    end else ref_cnt_o++;
  end
  always @(negedge chip_sel_n_i) if (exit_pend && $time - t_exit < 600) err_cnt_o++;
endmodule // psr_dev_model

// ### dv/testbench.sv
// Purpose: self-checking bench for the pseudo-static ram host
// Assumes: shortened power-up, refresh interval and self refresh counts
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ns
module testbench;
  logic sys_clk_i, rst_n_i, req_valid_i, req_write_i, self_refresh_req_i;
  logic [18:0] req_addr_i, addr_o;
  logic [7:0] req_wdata_i, rsp_rdata_o, data_i, data_o, q;
  logic req_ready_o, rsp_valid_o, self_refresh_o, init_done_o;
  logic cs_n, we_n, oe_n, data_oe_o;
  int ref_cnt, self_cnt, err_cnt, cyc, c0, fail_count, checked;
  psr_host #(.POWERUP_CNT(50), .REF_INT_CNT(80), .SR_PULSE_CNT(40)) i_psr_host (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .self_refresh_req_i(self_refresh_req_i), .self_refresh_o(self_refresh_o),
    .init_done_o(init_done_o), .chip_sel_n_o(cs_n), .write_strobe_n_o(we_n),
    .output_or_refresh_strobe_n_o(oe_n), .addr_o(addr_o), .data_i(data_i),
    .data_o(data_o), .data_oe_o(data_oe_o));
  psr_dev_model #(.SELF_NS(160)) i_psr_dev_model (
    .chip_sel_n_i(cs_n), .write_strobe_n_i(we_n), .output_or_refresh_strobe_n_n_i(oe_n), .addr_i(addr_o),
    .wdata_i(data_o), .host_oe_i(data_oe_o), .rdata_o(data_i), .ref_cnt_o(ref_cnt),
    .self_cnt_o(self_cnt), .err_cnt_o(err_cnt));
  initial begin
    sys_clk_i = 0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait, sampled at falling edges
  task automatic wait_lvl(input string what, ref logic sig, input logic lvl, input int n);
    int k = 0;
    while (sig !== lvl) begin
      @(negedge sys_clk_i);
      k++;
      if (k > n) begin
        check(what, 0, 1);
        give_verdict();
      end
    end
  endtask
  task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_valid_i <= 1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(negedge sys_clk_i);
    wait_lvl("ready", req_ready_o, 1, 300);
    @(posedge sys_clk_i);
    req_valid_i <= 0;
    if (!wr) begin
      @(negedge sys_clk_i);
      wait_lvl("rsp_valid", rsp_valid_o, 1, 60);
      q = rsp_rdata_o;
    end
  endtask
  task automatic t_init;
    @(negedge sys_clk_i);
    wait_lvl("init_done", init_done_o, 1, 3000);
    // power-up pause plus eight full refresh cycles of at least 29 clocks each
    check("powerup wait", (cyc - c0) > 50 + 8 * 29, 1);
    check("dummy cycles", ref_cnt, 8);
    $display("done init");
  endtask
  task automatic t_rw;
    for (int i = 0; i < 4; i++) access(1, 19'(i * 37), 8'ha5 ^ 8'(i));
    for (int i = 3; i >= 0; i--) begin
      access(0, 19'(i * 37), 8'h00);
      check("read back", q, 8'ha5 ^ 8'(i));
    end
    $display("done rw");
  endtask
  task automatic t_refresh;
    int r0 = ref_cnt;
    repeat (800) @(posedge sys_clk_i);
    check("refresh pace", (ref_cnt - r0) >= 9, 1);
    $display("done refresh");
  endtask
  task automatic t_self;
    int r0 = ref_cnt;
    @(posedge sys_clk_i);
    self_refresh_req_i <= 1;
    @(negedge sys_clk_i);
    wait_lvl("self entry", self_refresh_o, 1, 300);
    check("ready in self", req_ready_o, 0);
    repeat (200) @(posedge sys_clk_i);
    self_refresh_req_i <= 0;
    @(negedge sys_clk_i);
    wait_lvl("self exit", self_refresh_o, 0, 1000);
    repeat (60) @(posedge sys_clk_i);
    check("self pulses", self_cnt, 1);
    check("refresh after self", ref_cnt > r0, 1);
    access(0, 19'd37, 8'h00);
    check("kept data", q, 8'ha4);
    $display("done self");
  endtask
  initial begin
    {rst_n_i, req_valid_i, req_write_i, self_refresh_req_i} = 4'h0;
    req_addr_i = 19'h00000;
    req_wdata_i = 8'h00;
    {cyc, fail_count, checked} = 0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1;
    c0 = cyc;
    t_init();
    t_rw();
    t_refresh();
    t_self();
    check("device errors", err_cnt, 0);
    give_verdict();
  end
endmodule // testbench
